// *** core/act_consts.vh ***
`ifndef ACT_CONSTS_VH
`define ACT_CONSTS_VH
`define ACT_OFF_ACCF      4'h0
`define ACT_OFF_THRC      4'h1
`define ACT_OFF_STAT      4'h2
`define ACT_OFF_CLKD      4'h3
`define ACT_OFF_REFS      4'h4
`define ACT_OFF_CTRL      4'h5
`define ACT_OFF_RPT       4'h6
`define ACT_OFF_CNT       4'h7
`define ACT_OFF_STPT_L    4'h8
`define ACT_OFF_STPT_H    4'h9
`define ACT_OFF_UTH_L     4'hA
`define ACT_OFF_UTH_H     4'hB
`define ACT_OFF_LTH_L     4'hC
`define ACT_OFF_LTH_H     4'hD
`define ACT_OFF_FLT_L     4'hE
`define ACT_OFF_FLT_H     4'hF
`define ACT_PSIS_BIT      7
`define ACT_ACLR_BIT      3
`define ACT_SOI_BIT       3
`define ACT_NREF_BIT      4
`define ACT_CTRL_GO       0
`define ACT_CTRL_CONT     1
`define ACT_CTRL_DSEN     2
`define ACT_CTRL_TIF      3
`define ACT_MD_BASIC      3'h0
`define ACT_MD_ACC        3'h1
`define ACT_MD_AVG        3'h2
`define ACT_MD_BURST      3'h3
`define ACT_MD_LPF        3'h4
`define ACT_RESET_BYTE    8'h00
`define ACT_STAGE_IDLE    3'h0
`define ACT_STAGE_CONV1   3'h3
`define ACT_STAGE_CONV2   3'h7
`endif

// *** core/act_clk_div.v ***
`timescale 1ns/1ps
module act_clk_div (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire [5:0] clock_divide_select,
   output reg        adc_clk
);
   reg  [5:0] count;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count   <= 6'h00;
         adc_clk <= 1'b0;
      end else if (count >= clock_divide_select) begin
         count   <= 6'h00;
         adc_clk <= ~adc_clk;
      end else begin
         count <= count + 6'h01;
      end
   end
endmodule

// *** core/act_core.v ***
// What this block does
// - Previous sample loads filter or result at start
// - Low-pass time constant two to shift power
// - Accumulating modes shift accumulator; basic ignores shift
// - Shift divisions truncate, never round
// - Clear command clears accumulator, overflow, counter
// - Mode field selects five operating modes
// - Error codes 000/001/010 with double-sample variant
// - Error codes 100 and 101
// - Stop-on-threshold clears go in continuous mode
// - Threshold modes 000, 001, 010
// - Threshold modes 011 through 111
// - Overflow flag from accumulator or error
// - Upper and lower comparison flags
// - Computation-updated flag set by hardware, software clears
// - Stage field reports conversion phase
// - Clock select divides by two times (n+1)
// - Negative reference pin or ground
// - Positive reference buffer, pin or supply
// - Conversion counter saturates at maximum
// - Averaging modes compare once count reaches repeat
// - Filter output is shifted accumulator or filter
// - Threshold comparisons are signed
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "act_consts.vh"
module act_core #(
   parameter RES_W = 10,
   parameter ACC_W = 18
) (
   input  wire             clk_sys,
   input  wire             rst_b,
   input  wire [3:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_write,
   input  wire             reg_read,
   output reg  [7:0]       reg_rdata,
   input  wire             conv_done,
   input  wire [RES_W-1:0] conversion_result,
   input  wire [2:0]       analog_stage,
   output reg              conv_start,
   output reg              adc_clk,
   output reg              neg_ref_pin_sel,
   output reg  [1:0]       pos_ref_route,
   output reg              threshold_flag
);
   reg         rst_meta;
   reg         rst_n;
   reg  [7:0]  accf;
   reg  [6:0]  thrc;
   reg  [5:0]  clock_divide_select;
   reg         neg_ref_select;
   reg  [1:0]  pos_ref_select;
   reg         conversion_go;
   reg         continuous_enable;
   reg         double_sample_enable;
   reg  [7:0]  repeat_setting;
   reg  [7:0]  conversion_counter;
   reg  [15:0] setpoint;
   reg  [15:0] upper_threshold;
   reg  [15:0] lower_threshold;
   reg  [15:0] filter_output;
   reg  [15:0] previous_sample;
   reg  [15:0] first_sample;
   reg  [15:0] last_result;
   reg  [ACC_W-1:0] accumulator;
   reg  [15:0] error_value;
   reg         compute_overflow;
   reg         above_upper_flag;
   reg         below_lower_flag;
   reg         compute_updated;
   reg         second_pending;
   reg         go_q;
   reg  [2:0]  stage_status;
   wire        adc_clk_int;
   wire [2:0]  compute_mode = accf[2:0];
   wire [2:0]  shift_select = accf[6:4];
   wire [2:0]  error_calc_select = thrc[6:4];
   wire        stop_on_threshold = thrc[`ACT_SOI_BIT];
   wire [2:0]  threshold_mode = thrc[2:0];
   wire        is_accum = (compute_mode == `ACT_MD_ACC) ||
                          (compute_mode == `ACT_MD_AVG) ||
                          (compute_mode == `ACT_MD_BURST);
   wire        is_rpt = (compute_mode == `ACT_MD_AVG) ||
                        (compute_mode == `ACT_MD_BURST) ||
                        (compute_mode == `ACT_MD_LPF);

   act_clk_div u_div (
      .clk_sys             (clk_sys),
      .rst_n               (rst_n),
      .clock_divide_select (clock_divide_select),
      .adc_clk             (adc_clk_int)
   );

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Computation on a completed sample.
   reg  [15:0] sample;
   reg  [ACC_W:0] acc_sum;
   reg  [ACC_W-1:0] acc_shift;
   reg  signed [17:0] lpf_step;
   reg  [15:0] lpf_next;
   reg  [15:0] flt_next;
   reg  [15:0] prev_use;
   reg  signed [16:0] err_a;
   reg  signed [16:0] err_b;
   reg  signed [17:0] err_full;
   reg         err_ovf;
   reg  [7:0]  next_count;
   reg         compare_now;
   reg         hit_upper;
   reg         hit_lower;
   reg         hit_met;
   always @* begin
      sample    = {{(16-RES_W){1'b0}}, conversion_result};
      acc_sum   = {1'b0, accumulator} + {{(ACC_W+1-16){1'b0}}, sample};
      acc_shift = acc_sum[ACC_W-1:0] >> shift_select;
      lpf_step  = ($signed({2'b00, sample}) -
                   $signed({2'b00, filter_output})) >>> shift_select;
      lpf_next  = filter_output + lpf_step[15:0];
      next_count = (conversion_counter == 8'hFF) ? 8'hFF :
                   conversion_counter + 8'h01;
      // Error terms see the filter value that this sample produces.
      if (is_accum)
         flt_next = acc_shift[15:0];
      else if (compute_mode == `ACT_MD_LPF)
         flt_next = lpf_next;
      else
         flt_next = filter_output;
      // A second sample is judged against the first one of its pair.
      prev_use = (double_sample_enable && second_pending) ?
                 first_sample : previous_sample;
      err_a = $signed({1'b0, sample});
      if (double_sample_enable && (error_calc_select == 3'h1 ||
          error_calc_select == 3'h2))
         err_a = $signed({1'b0, sample}) -
                 $signed({1'b0, prev_use});
      case (error_calc_select)
         3'h0: begin
            err_a = $signed({1'b0, sample});
            err_b = $signed({1'b0, prev_use});
         end
         3'h1: err_b = $signed({1'b0, setpoint});
         3'h2: err_b = $signed({1'b0, flt_next});
         3'h4: begin
            err_a = $signed({1'b0, prev_use});
            err_b = $signed({1'b0, flt_next});
         end
         3'h5: begin
            err_a = $signed({1'b0, flt_next});
            err_b = $signed({1'b0, setpoint});
         end
         default: begin
            err_a = 17'sh00000;
            err_b = 17'sh00000;
         end
      endcase
      err_full = {err_a[16], err_a} - {err_b[16], err_b};
      err_ovf  = (err_full[17:15] != 3'b000) &&
                 (err_full[17:15] != 3'b111);
      hit_upper = $signed(err_full[15:0]) >
                  $signed(upper_threshold);
      hit_lower = $signed(err_full[15:0]) <
                  $signed(lower_threshold);
      case (threshold_mode)
         3'h0: hit_met = 1'b0;
         3'h1: hit_met = hit_lower;
         3'h2: hit_met = !hit_lower;
         3'h3: hit_met = ($signed(err_full[15:0]) >
                          $signed(lower_threshold)) &&
                         ($signed(err_full[15:0]) <
                          $signed(upper_threshold));
         3'h4: hit_met = hit_lower || hit_upper;
         3'h5: hit_met = !hit_upper;
         3'h6: hit_met = hit_upper;
         default: hit_met = 1'b1;
      endcase
      compare_now = !(double_sample_enable && !second_pending) &&
                    (!is_rpt || next_count >= repeat_setting);
   end

   wire wr_accf = reg_write && reg_addr == `ACT_OFF_ACCF;
   wire wr_stat = reg_write && reg_addr == `ACT_OFF_STAT;
   wire wr_ctrl = reg_write && reg_addr == `ACT_OFF_CTRL;
   wire go_rise = conversion_go && !go_q;
   wire clr_now = accf[`ACT_ACLR_BIT];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         accf <= `ACT_RESET_BYTE;
         thrc <= 7'h00;
         clock_divide_select <= 6'h00;
         neg_ref_select <= 1'b0;
         pos_ref_select <= 2'h0;
         conversion_go <= 1'b0;
         continuous_enable <= 1'b0;
         double_sample_enable <= 1'b0;
         repeat_setting <= 8'h00;
         conversion_counter <= 8'h00;
         setpoint <= 16'h0000;
         upper_threshold <= 16'h0000;
         lower_threshold <= 16'h0000;
         filter_output <= 16'h0000;
         previous_sample <= 16'h0000;
         first_sample <= 16'h0000;
         last_result <= 16'h0000;
         accumulator <= {ACC_W{1'b0}};
         error_value <= 16'h0000;
         compute_overflow <= 1'b0;
         above_upper_flag <= 1'b0;
         below_lower_flag <= 1'b0;
         compute_updated <= 1'b0;
         second_pending <= 1'b0;
         go_q <= 1'b0;
         threshold_flag <= 1'b0;
         conv_start <= 1'b0;
         stage_status <= `ACT_STAGE_IDLE;
         reg_rdata <= 8'h00;
         adc_clk <= 1'b0;
         neg_ref_pin_sel <= 1'b0;
         pos_ref_route <= 2'h0;
      end else begin
         go_q <= conversion_go;
         conv_start <= go_rise;
         adc_clk <= adc_clk_int;
         neg_ref_pin_sel <= neg_ref_select;
         pos_ref_route <= (pos_ref_select == 2'h1) ? 2'h0 :
                          pos_ref_select;
         stage_status <= (analog_stage == 3'h4) ? `ACT_STAGE_IDLE :
                         analog_stage;
         if (go_rise) begin
            previous_sample <= accf[`ACT_PSIS_BIT] ? filter_output :
                               last_result;
         end
         if (reg_write) begin
            case (reg_addr)
               `ACT_OFF_ACCF: accf <= reg_wdata;
               `ACT_OFF_THRC: thrc <= reg_wdata[6:0];
               `ACT_OFF_CLKD: clock_divide_select <= reg_wdata[5:0];
               `ACT_OFF_REFS: begin
                  neg_ref_select <= reg_wdata[`ACT_NREF_BIT];
                  pos_ref_select <= reg_wdata[1:0];
               end
               `ACT_OFF_RPT: repeat_setting <= reg_wdata;
               `ACT_OFF_CNT: conversion_counter <= reg_wdata;
               `ACT_OFF_STPT_L: setpoint[7:0] <= reg_wdata;
               `ACT_OFF_STPT_H: setpoint[15:8] <= reg_wdata;
               `ACT_OFF_UTH_L: upper_threshold[7:0] <= reg_wdata;
               `ACT_OFF_UTH_H: upper_threshold[15:8] <= reg_wdata;
               `ACT_OFF_LTH_L: lower_threshold[7:0] <= reg_wdata;
               `ACT_OFF_LTH_H: lower_threshold[15:8] <= reg_wdata;
               default: begin
               end
            endcase
         end
         if (wr_ctrl) begin
            conversion_go <= reg_wdata[`ACT_CTRL_GO];
            continuous_enable <= reg_wdata[`ACT_CTRL_CONT];
            double_sample_enable <= reg_wdata[`ACT_CTRL_DSEN];
            if (!reg_wdata[`ACT_CTRL_TIF])
               threshold_flag <= 1'b0;
         end
         if (wr_stat && !reg_wdata[4])
            compute_updated <= 1'b0;
         // The clear lands one cycle after the command write.
         if (clr_now && !wr_accf) begin
            accumulator <= {ACC_W{1'b0}};
            compute_overflow <= 1'b0;
            conversion_counter <= 8'h00;
            accf[`ACT_ACLR_BIT] <= 1'b0;
         end else if (conv_done) begin
            last_result <= sample;
            conversion_counter <= next_count;
            compute_updated <= 1'b1;
            if (double_sample_enable && !second_pending) begin
               first_sample <= sample;
               second_pending <= 1'b1;
            end else begin
               second_pending <= 1'b0;
               if (double_sample_enable)
                  previous_sample <= first_sample;
            end
            if (compute_mode != `ACT_MD_BASIC) begin
               accumulator <= acc_sum[ACC_W-1:0];
               if (acc_sum[ACC_W])
                  compute_overflow <= 1'b1;
            end
            if (is_accum)
               filter_output <= acc_shift[15:0];
            else if (compute_mode == `ACT_MD_LPF)
               filter_output <= lpf_next;
            if (compare_now) begin
               error_value <= err_full[15:0];
               above_upper_flag <= hit_upper;
               below_lower_flag <= hit_lower;
               if (err_ovf)
                  compute_overflow <= 1'b1;
               if (hit_met || err_ovf)
                  threshold_flag <= 1'b1;
            end
            if (!continuous_enable &&
                !(compute_mode == `ACT_MD_BURST && !compare_now))
               conversion_go <= 1'b0;
            else if (continuous_enable && stop_on_threshold &&
                     compare_now && hit_met)
               conversion_go <= 1'b0;
         end
         if (reg_read) begin
            case (reg_addr)
               `ACT_OFF_ACCF: reg_rdata <= accf;
               `ACT_OFF_THRC: reg_rdata <= {1'b0, thrc};
               `ACT_OFF_STAT: reg_rdata <= {compute_overflow,
                  above_upper_flag, below_lower_flag, compute_updated,
                  1'b0, stage_status};
               `ACT_OFF_CLKD: reg_rdata <= {2'b00, clock_divide_select};
               `ACT_OFF_REFS: reg_rdata <= {3'b000, neg_ref_select,
                  2'b00, pos_ref_select};
               `ACT_OFF_CTRL: reg_rdata <= {4'h0, threshold_flag,
                  double_sample_enable, continuous_enable, conversion_go};
               `ACT_OFF_RPT: reg_rdata <= repeat_setting;
               `ACT_OFF_CNT: reg_rdata <= conversion_counter;
               `ACT_OFF_STPT_L: reg_rdata <= setpoint[7:0];
               `ACT_OFF_STPT_H: reg_rdata <= setpoint[15:8];
               `ACT_OFF_UTH_L: reg_rdata <= upper_threshold[7:0];
               `ACT_OFF_UTH_H: reg_rdata <= upper_threshold[15:8];
               `ACT_OFF_LTH_L: reg_rdata <= lower_threshold[7:0];
               `ACT_OFF_LTH_H: reg_rdata <= lower_threshold[15:8];
               `ACT_OFF_FLT_L: reg_rdata <= filter_output[7:0];
               default: reg_rdata <= filter_output[15:8];
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule

// *** sim/act_core_sva.sv ***
`timescale 1ns/1ps
module act_core_sva (
   input wire       clk_sys,
   input wire       rst_b,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_write,
   input wire       reg_read,
   input wire [7:0] reg_rdata,
   input wire [2:0] analog_stage,
   input wire       conv_start,
   input wire       adc_clk,
   input wire       neg_ref_pin_sel,
   input wire [1:0] pos_ref_route,
   input wire       threshold_flag
);
   reg  [5:0] div;
   reg  [7:0] run;
   reg  [1:0] tog;
   reg        clk_q;
   reg  [7:0] ref_q;
   wire       flip = adc_clk != clk_q;
   function [7:0] rsv_mask(input [3:0] a);
      case (a)
         4'h1: rsv_mask = 8'h80;
         4'h2: rsv_mask = 8'h08;
         4'h3: rsv_mask = 8'hC0;
         4'h4: rsv_mask = 8'hEC;
         4'h5: rsv_mask = 8'hF0;
         default: rsv_mask = 8'h00;
      endcase
   endfunction
   // Tracks divider writes and the length of each half period.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div <= 6'h00;
         run <= 8'h00;
         tog <= 2'h0;
         clk_q <= 1'b0;
         ref_q <= 8'h00;
      end else begin
         clk_q <= adc_clk;
         run <= flip ? 8'h01 : run + 8'h01;
         if (reg_write && reg_addr == 4'h4) ref_q <= reg_wdata;
         if (reg_write && reg_addr == 4'h3) begin
            div <= reg_wdata[5:0];
            tog <= 2'h0;
         end else if (flip && tog != 2'h2) begin
            tog <= tog + 2'h1;
         end
      end
   end
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_RDATA_QUIET: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   AST_RSV_ZERO: assert property (reg_read |=>
      (reg_rdata & rsv_mask($past(reg_addr))) == 8'h00)
      else $error("reserved bits not zero");
   AST_STAGE_READ: assert property (reg_read && reg_addr == 4'h2 &&
      $stable(analog_stage) |=> reg_rdata[2:0] ==
      ($past(analog_stage) == 3'h4 ? 3'h0 : $past(analog_stage)))
      else $error("stage readback wrong");
   AST_NREF: assert property (reg_write && reg_addr == 4'h4 |->
      ##[1:2] neg_ref_pin_sel == ref_q[4])
      else $error("negative reference select wrong");
   AST_PREF: assert property (reg_write && reg_addr == 4'h4 |->
      ##[1:2] pos_ref_route == (ref_q[1:0] == 2'b01 ? 2'b00 : ref_q[1:0]))
      else $error("positive reference route wrong");
   AST_CLK_DIV: assert property (flip && tog == 2'h2 |->
      run == {2'b00, div} + 8'h01)
      else $error("divided clock half period wrong");
   AST_TIF_CLEAR: assert property ($fell(threshold_flag) |->
      $past(reg_write && reg_addr == 4'h5 && !reg_wdata[3]) ||
      $past(reg_write && reg_addr == 4'h5 && !reg_wdata[3], 2))
      else $error("threshold flag dropped without clear");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("start pulse too long");
endmodule
bind act_core act_core_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .analog_stage(analog_stage),
   .conv_start(conv_start), .adc_clk(adc_clk),
   .neg_ref_pin_sel(neg_ref_pin_sel), .pos_ref_route(pos_ref_route),
   .threshold_flag(threshold_flag));

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   reg        clk_sys = 1'b0;
   reg        rst_b = 1'b0;
   reg  [3:0] addr = 4'h0;
   reg  [7:0] wdata = 8'h00;
   reg        wr_s = 1'b0;
   reg        rd_s = 1'b0;
   reg        done = 1'b0;
   reg  [9:0] res = 10'h000;
   reg  [2:0] stage = 3'h0;
   wire [7:0] rdata;
   wire       start;
   wire       aclk;
   wire       nref;
   wire [1:0] pref;
   wire       tif;
   integer    err_count = 0;
   integer    samples_checked = 0;
   integer    i;
   integer    k;
   reg  [7:0] v;
   always #2 clk_sys = ~clk_sys;
   act_core #(.RES_W(10), .ACC_W(18)) u_dut (.clk_sys(clk_sys),
      .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
      .reg_read(rd_s), .reg_rdata(rdata), .conv_done(done),
      .conversion_result(res), .analog_stage(stage), .conv_start(start),
      .adc_clk(aclk), .neg_ref_pin_sel(nref), .pos_ref_route(pref),
      .threshold_flag(tif));
   task complete_run;
      begin
         if (err_count == 0 && samples_checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr_s <= 1'b1;
         @(posedge clk_sys);
         wr_s <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task rd(input [3:0] a, output [7:0] d);
      begin
         addr <= a;
         rd_s <= 1'b1;
         @(posedge clk_sys);
         rd_s <= 1'b0;
         #1 d = rdata;
         @(posedge clk_sys);
      end
   endtask
   task conv(input [9:0] r);
      begin
         res <= r;
         done <= 1'b1;
         @(posedge clk_sys);
         done <= 1'b0;
         tick(6);
      end
   endtask
   function [7:0] want(input [2:0] m, input integer e);
      case (m)
         3'h0: want = 0;
         3'h1: want = e < -20;
         3'h2: want = e >= -20;
         3'h3: want = e > -20 && e < 50;
         3'h4: want = e < -20 || e > 50;
         3'h5: want = e <= 50;
         3'h6: want = e > 50;
         default: want = 1;
      endcase
   endfunction
   task t_reset_stage;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            rd(i, v);
            chk(v, 8'h00);
         end
         for (i = 0; i < 8; i = i + 1) if (i != 4) begin
            stage <= i;
            tick(2);
            rd(4'h2, v);
            chk({5'h00, v[2:0]}, i);
         end
         stage <= 3'h0;
      end
   endtask
   task t_ref;
      for (i = 0; i < 8; i = i + 1) begin
         wr(4'h4, {3'h0, i[2], 2'h0, i[1:0]});
         tick(1);
         chk({7'h00, nref}, {7'h00, i[2]});
         chk({6'h00, pref}, i[1:0] == 1 ? 8'h00 : i[1:0]);
         rd(4'h4, v);
         chk(v, {3'h0, i[2], 2'h0, i[1:0]});
      end
   endtask
   task t_div(input [5:0] n);
      integer c, t0, t1;
      reg p;
      begin
         wr(4'h3, {2'h0, n});
         tick(300);
         t0 = -1;
         t1 = -1;
         p = aclk;
         for (c = 0; c < 600 && t1 < 0; c = c + 1) begin
            @(posedge clk_sys);
            #1 if (aclk === 1'b1 && p === 1'b0) begin
               if (t0 < 0) t0 = c;
               else t1 = c;
            end
            p = aclk;
         end
         chk(t1 - t0, {1'b0, n, 1'b0} + 8'h02);
         tick(1);
      end
   endtask
   task t_accum;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            wr(4'h0, i);
            rd(4'h0, v);
            chk(v, i);
         end
         wr(4'h0, 8'h29);
         tick(3);
         conv(10'd7);
         conv(10'd6);
         rd(4'hE, v);
         chk(v, 8'h03);
         rd(4'hF, v);
         chk(v, 8'h00);
         rd(4'h7, v);
         chk(v, 8'h02);
         wr(4'h0, 8'h29);
         tick(3);
         rd(4'h0, v);
         chk(v, 8'h21);
         rd(4'h7, v);
         chk(v, 8'h00);
         wr(4'h7, 8'hFE);
         for (i = 0; i < 3; i = i + 1) conv(10'd1);
         rd(4'h7, v);
         chk(v, 8'hFF);
      end
   endtask
   task t_thr;
      integer e;
      begin
         wr(4'h0, 8'h00);
         wr(4'h8, 8'h64);
         wr(4'h9, 8'h00);
         wr(4'hA, 8'h32);
         wr(4'hB, 8'h00);
         wr(4'hC, 8'hEC);
         wr(4'hD, 8'hFF);
         for (i = 0; i < 8; i = i + 1) for (k = 0; k < 5; k = k + 1) begin
            e = k == 0 ? -30 : k == 1 ? 0 : k == 2 ? 60 : k == 3 ? 50 : -20;
            wr(4'h5, 8'h00);
            wr(4'h1, {4'h1, 1'b0, i[2:0]});
            conv(100 + e);
            chk({7'h00, tif}, want(i, e));
            rd(4'h2, v);
            chk({5'h00, v[6:4]}, {5'h00, e > 50, e < -20, 1'b1});
         end
         wr(4'h2, 8'h00);
         rd(4'h2, v);
         chk({7'h00, v[4]}, 8'h00);
         wr(4'h1, 8'h06);
         conv(10'd200);
         wr(4'h5, 8'h01);
         conv(10'd300);
         chk({7'h00, tif}, 8'h01);
         wr(4'h5, 8'h01);
         conv(10'd310);
         chk({7'h00, tif}, 8'h00);
      end
   endtask
   task t_soi;
      begin
         wr(4'h1, 8'h0F);
         wr(4'h5, 8'h03);
         #1 chk({7'h00, start}, 8'h01);
         tick(1);
         conv(10'd500);
         chk({7'h00, tif}, 8'h01);
         rd(4'h5, v);
         chk({7'h00, v[0]}, 8'h00);
         wr(4'h1, 8'h07);
         wr(4'h5, 8'h03);
         conv(10'd500);
         rd(4'h5, v);
         chk({7'h00, v[0]}, 8'h01);
         wr(4'h5, 8'h00);
      end
   endtask
   task t_calc;
      begin
         wr(4'h6, 8'h02);
         wr(4'h0, 8'h1A);
         wr(4'h1, 8'h57);
         wr(4'h5, 8'h00);
         conv(10'd31);
         chk({7'h00, tif}, 8'h00);
         conv(10'd40);
         chk({7'h00, tif}, 8'h01);
         rd(4'hE, v);
         chk(v, 8'h23);
         rd(4'h2, v);
         chk({5'h00, v[6:4]}, 8'h03);
         wr(4'h1, 8'h46);
         wr(4'h5, 8'h00);
         conv(10'd0);
         chk({7'h00, tif}, 8'h01);
         wr(4'h0, 8'h1C);
         conv(10'd99);
         rd(4'hE, v);
         chk(v, 8'h43);
         conv(10'd0);
         rd(4'hE, v);
         chk(v, 8'h21);
         wr(4'h0, 8'h00);
         wr(4'h9, 8'h90);
         wr(4'h1, 8'h10);
         wr(4'h5, 8'h00);
         conv(10'd10);
         chk({7'h00, tif}, 8'h01);
         rd(4'h2, v);
         chk({7'h00, v[7]}, 8'h01);
         rd(4'hE, v);
         chk(v, 8'h21);
         wr(4'h0, 8'h08);
         rd(4'h2, v);
         chk({7'h00, v[7]}, 8'h00);
         wr(4'h9, 8'h00);
         wr(4'h8, 8'h00);
         wr(4'h1, 8'h16);
         wr(4'h5, 8'h04);
         conv(10'd100);
         chk({7'h00, tif}, 8'h00);
         conv(10'd200);
         chk({7'h00, tif}, 8'h01);
         wr(4'h0, 8'h0B);
         wr(4'h5, 8'h01);
         conv(10'd1);
         rd(4'h5, v);
         chk({7'h00, v[0]}, 8'h01);
         conv(10'd1);
         rd(4'h5, v);
         chk({7'h00, v[0]}, 8'h00);
      end
   endtask
   initial begin
      #100000;
      err_count = err_count + 1;
      complete_run;
   end
   initial begin
      tick(6);
      rst_b <= 1'b1;
      tick(3);
      t_reset_stage;
      t_ref;
      t_div(6'd0);
      t_div(6'd1);
      t_div(6'd63);
      t_accum;
      t_thr;
      t_soi;
      t_calc;
      complete_run;
   end
endmodule
